// File: hw/aro_pkg.sv
/*
 * Shared constants and types for the converter readout and oversampling block.
 * Assumes a single clock domain for conversion control plus a host serial clock.
 */
package aro_pkg;

    // ==========================================================
    // result and channel geometry
    localparam int              CH_NUM      = 8;
    localparam int              RES_W       = 14;
    localparam int              ACC_W       = RES_W + 6;
    localparam logic [3:0]      BIT_LAST    = 4'h000D;
    localparam logic [2:0]      LANE_B_OFS  = 3'h4;
    localparam logic [4:0]      FLAG_BYTES  = 5'h0002;

    // ==========================================================
    // oversampling ratio codes
    localparam logic [2:0]      OS_NONE     = 3'h0;
    localparam logic [2:0]      OS_INVALID  = 3'h7;

    // ==========================================================
    // reset values
    localparam logic [2:0]      RATIO_RST   = 3'h0;
    localparam logic [6:0]      CNT_RST     = 7'h00;
    localparam logic [4:0]      RD_CNT_RST  = 5'h00;

    typedef logic signed [RES_W-1:0] aro_res_t;
    typedef logic signed [ACC_W-1:0] aro_acc_t;

    typedef struct packed {
        logic serial;
        logic byte_wide;
        logic high_first;
    } aro_cfg_s;

    localparam aro_cfg_s        CFG_RST     = '0;

endpackage

// File: hw/aro_readout.sv
/*
 * Result readout (byte-wide and dual-lane serial) with sinc1 oversampling control.
 * Assumes a converter core on sys_clk_i answering sample_req_o with sample_valid_i,
 * and a host serial clock sclk_i that also pulses between chip-select frames so the new-data toggle can cross.
 */
// What this block does
// - byte mode: two transfers per channel, sixteen
// - byte data on low eight lines only
// - byte order input chooses high byte first
// - flag high until the first read of channel 2
// - upper byte carries two sign copies
// - lane A channels 1-4, lane B 5-8
// - chip select fall shows MSB, rising shifts
// - lane B alone gives 5-8 then 1-4
// - serial flag with channel 1 on A
// - lane B only: flag with channel 5
// - reads allowed while busy, previous results
// - results update on busy falling edge
// - ratio captured at busy fall, next conversion
// - ratio code decode, 111 invalid
// - sinc1 filter when oversampling selected
// - trigger raises busy until all converted
// - read strobes give channels ascending
// - trigger starts first sample, rest internal
`timescale 1ns/1ns
module aro_readout
    import aro_pkg::*;
(
    input  wire logic                     sys_clk_i,
    input  wire logic                     rst_n_i,
    input  wire logic                     sclk_i,
    input  wire logic                     sample_trigger_i,
    input  wire logic [2:0]               ratio_select_i,
    input  wire logic                     interface_select_i,
    input  wire logic                     byte_mode_select_i,
    input  wire logic                     high_byte_first_i,
    input  wire logic                     cs_n_i,
    input  wire logic                     rd_n_i,
    input  wire logic [CH_NUM*RES_W-1:0]  sample_data_i,
    input  wire logic                     sample_valid_i,
    output logic                          sample_req_o,
    output logic                          busy_o,
    output logic [7:0]                    byte_bus_o,
    output logic                          byte_bus_oe_o,
    output logic                          serial_out_a_o,
    output logic                          serial_out_a_oe_o,
    output logic                          serial_out_b_o,
    output logic                          serial_out_b_oe_o,
    output logic                          first_channel_flag_o,
    output logic                          first_channel_flag_oe_o
);

    typedef enum {ST_IDLE, ST_REQ, ST_WAIT} aro_state_e;

    // ==========================================================
    // pin synchronisers (system domain)
    logic [2:0] ratio_s1_q, ratio_s2_q;
    aro_cfg_s   cfg_s1_q, cfg_s2_q, cfg_q;
    logic       trig_s1_q, trig_s2_q, trig_s3_q;
    logic       cs_s1_q, cs_s2_q, rd_s1_q, rd_s2_q, rd_s3_q;

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            ratio_s1_q <= RATIO_RST;
            ratio_s2_q <= RATIO_RST;
            cfg_s1_q   <= CFG_RST;
            cfg_s2_q   <= CFG_RST;
            trig_s1_q  <= 1'b0;
            trig_s2_q  <= 1'b0;
            trig_s3_q  <= 1'b0;
            cs_s1_q    <= 1'b1;
            cs_s2_q    <= 1'b1;
            rd_s1_q    <= 1'b1;
            rd_s2_q    <= 1'b1;
            rd_s3_q    <= 1'b1;
        end
        else
        begin
            ratio_s1_q <= ratio_select_i;
            ratio_s2_q <= ratio_s1_q;
            cfg_s1_q   <= '{serial: interface_select_i, byte_wide: byte_mode_select_i,
                            high_first: high_byte_first_i};
            cfg_s2_q   <= cfg_s1_q;
            trig_s1_q  <= sample_trigger_i;
            trig_s2_q  <= trig_s1_q;
            trig_s3_q  <= trig_s2_q;
            cs_s1_q    <= cs_n_i;
            cs_s2_q    <= cs_s1_q;
            rd_s1_q    <= rd_n_i;
            rd_s2_q    <= rd_s1_q;
            rd_s3_q    <= rd_s2_q;
        end
    end

    logic trig_rise, rd_fall, byte_mode, serial_mode;
    assign trig_rise   = trig_s2_q & ~trig_s3_q;
    assign rd_fall     = ~rd_s2_q & rd_s3_q & ~cs_s2_q;
    assign byte_mode   = cfg_q.serial & cfg_q.byte_wide;
    assign serial_mode = cfg_q.serial & ~cfg_q.byte_wide;

    // ==========================================================
    // conversion sequencer and sinc1 accumulation
    aro_state_e state_q;
    logic [2:0] ratio_q;
    logic [2:0] shift_amt;
    logic [6:0] cnt_q, n_samples;
    logic       finish;
    aro_acc_t   acc_q [CH_NUM];
    aro_acc_t   sum_d [CH_NUM];
    aro_res_t   avg_d [CH_NUM];
    aro_res_t   result_q [CH_NUM];
    logic       new_tog_q;
    logic       ack_s1_q, ack_s2_q;

    // invalid code falls back to a single sample rather than stalling busy
    assign shift_amt = (ratio_q == OS_INVALID) ? OS_NONE : ratio_q;
    assign n_samples = 7'(7'h01 << shift_amt);
    assign finish    = (state_q == ST_WAIT) & sample_valid_i & (cnt_q + 7'h01 == n_samples);

    always_comb
    begin
        for (int c = 0; c < CH_NUM; c++)
        begin
            sum_d[c] = acc_q[c] + ACC_W'($signed(sample_data_i[c*RES_W +: RES_W]));
            // round half up, then arithmetic shift by log2 of the ratio
            avg_d[c] = RES_W'((sum_d[c] + ACC_W'((7'h01 << shift_amt) >> 1)) >>> shift_amt);
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            state_q      <= ST_IDLE;
            cnt_q        <= CNT_RST;
            sample_req_o <= 1'b0;
        end
        else
        begin
            sample_req_o <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    cnt_q <= CNT_RST;
                    if (trig_rise)
                        state_q <= ST_REQ;
                end
                ST_REQ:
                begin
                    sample_req_o <= 1'b1;
                    state_q      <= ST_WAIT;
                end
                ST_WAIT:
                begin
                    if (sample_valid_i)
                    begin
                        cnt_q <= cnt_q + 7'h01;
                        // further samples are strobed internally, no new trigger
                        state_q <= finish ? ST_IDLE : ST_REQ;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    assign busy_o = (state_q != ST_IDLE);

    always_ff @(posedge sys_clk_i)
    begin
        for (int c = 0; c < CH_NUM; c++)
        begin
            if (!rst_n_i || state_q == ST_IDLE)
                acc_q[c] <= '0;
            else if (state_q == ST_WAIT && sample_valid_i)
                acc_q[c] <= sum_d[c];
        end
    end

    // results stay put during busy, so reads return the previous conversion
    always_ff @(posedge sys_clk_i)
    begin
        for (int c = 0; c < CH_NUM; c++)
        begin
            if (!rst_n_i)
                result_q[c] <= '0;
            else if (finish)
                result_q[c] <= avg_d[c];
        end
    end

    // mode and ratio only change between sweeps
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            ratio_q   <= RATIO_RST;
            cfg_q     <= CFG_RST;
            new_tog_q <= 1'b0;
        end
        else if (finish)
        begin
            ratio_q   <= ratio_s2_q;
            cfg_q     <= cfg_s2_q;
            // flip only once the host side has seen the last flip; an unseen
            // second flip would cancel the first and the sweep would be lost
            if (new_tog_q == ack_s2_q)
            begin
                new_tog_q <= ~new_tog_q;
            end
        end
    end

    // ==========================================================
    // byte-wide readout
    logic [4:0] rd_cnt_q;
    logic       hi_sel;
    aro_res_t   byte_word;

    assign byte_word = result_q[rd_cnt_q[3:1]];
    assign hi_sel    = rd_cnt_q[0] ^ cfg_q.high_first;

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i || finish)
            rd_cnt_q <= RD_CNT_RST;
        else if (rd_fall && byte_mode)
            rd_cnt_q <= rd_cnt_q + 5'h01;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
            byte_bus_o <= 8'h00;
        else if (rd_fall && byte_mode)
            byte_bus_o <= hi_sel ? {{2{byte_word[RES_W-1]}}, byte_word[RES_W-1:8]}
                                 : byte_word[7:0];
    end

    assign byte_bus_oe_o = byte_mode & ~cs_s2_q & ~rd_s2_q;

    // ==========================================================
    // serial domain: reset and new-data toggle crossing
    logic srst_s1_q, srst_s2_q, tog_s1_q, tog_s2_q, tog_seen_q, pending;
    logic [3:0] bit_q, bit_eff;
    logic [2:0] ch_q, ch_eff;
    aro_res_t   shadow_q [CH_NUM];
    aro_res_t   word_a, word_b;

    always_ff @(posedge sclk_i)
    begin
        srst_s1_q <= rst_n_i;
        srst_s2_q <= srst_s1_q;
        tog_s1_q  <= new_tog_q;
        tog_s2_q  <= tog_s1_q;
    end

    // acknowledge of the new-data toggle back into the system domain
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
        end
        else
        begin
            ack_s1_q <= tog_seen_q;
            ack_s2_q <= ack_s1_q;
        end
    end

    // fresh sweep pending: restart at channel 1 without needing an edge first
    assign pending = tog_s2_q ^ tog_seen_q;
    assign bit_eff = pending ? 4'h0 : bit_q;
    assign ch_eff  = pending ? 3'h0 : ch_q;

    always_ff @(posedge sclk_i)
    begin
        if (!srst_s2_q)
        begin
            bit_q      <= 4'h0;
            ch_q       <= 3'h0;
            tog_seen_q <= 1'b0;
        end
        else if (!cs_n_i)
        begin
            if (pending)
            begin
                tog_seen_q <= tog_s2_q;
                bit_q      <= 4'h1;
                ch_q       <= 3'h0;
            end
            else if (bit_q == BIT_LAST)
            begin
                bit_q <= 4'h0;
                ch_q  <= ch_q + 3'h1;
            end
            else
                bit_q <= bit_q + 4'h1;
        end
    end

    // copy taken once per sweep; result_q is quiet by then since busy fell earlier
    always_ff @(posedge sclk_i)
    begin
        for (int c = 0; c < CH_NUM; c++)
        begin
            if (!cs_n_i && pending)
                shadow_q[c] <= result_q[c];
        end
    end

    assign word_a = pending ? result_q[ch_eff] : shadow_q[ch_eff];
    assign word_b = pending ? result_q[ch_eff + LANE_B_OFS]
                            : shadow_q[ch_eff + LANE_B_OFS];

    assign serial_out_a_o    = word_a[BIT_LAST - bit_eff];
    assign serial_out_b_o    = word_b[BIT_LAST - bit_eff];
    assign serial_out_a_oe_o = serial_mode & ~cs_n_i;
    assign serial_out_b_oe_o = serial_mode & ~cs_n_i;

    // ==========================================================
    // first channel flag, shared by both readout modes
    logic ser_flag;
    // channel 1 on lane A coincides with channel 5 on lane B
    assign ser_flag = (ch_eff == 3'h0);

    assign first_channel_flag_o    = serial_mode ? ser_flag : (rd_cnt_q <= FLAG_BYTES);
    assign first_channel_flag_oe_o = serial_mode ? ~cs_n_i
                                                 : (byte_mode & ~cs_s2_q);

    // ==========================================================
    // checks
    AST_BUSY_RISE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        state_q == ST_IDLE && trig_rise |=> busy_o)
        else $error("busy did not rise after trigger");
    AST_BUSY_FALL: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        $fell(busy_o) |-> $past(sample_valid_i) && $past(cnt_q) + 7'h01 == $past(n_samples))
        else $error("busy fell before all samples");
    AST_RATIO_LATCH: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        $fell(busy_o) |-> ratio_q == $past(ratio_s2_q))
        else $error("ratio not captured at busy fall");
    AST_RESULT_UPD: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        $fell(busy_o) |-> result_q[0] == $past(avg_d[0]) && result_q[7] == $past(avg_d[7]))
        else $error("results not updated at busy fall");
    AST_RESULT_HOLD: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        busy_o && $past(busy_o) |-> $stable(result_q[3]))
        else $error("results changed during conversion");
    AST_NEXT_STROBE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        state_q == ST_WAIT && sample_valid_i && !finish |=> ##1 sample_req_o)
        else $error("internal sample strobe missing");
    AST_FIRST_BYTE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        $fell(busy_o) |-> rd_cnt_q == RD_CNT_RST)
        else $error("read pointer not restarted");
    AST_BYTE_ORDER: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        rd_fall && byte_mode && rd_cnt_q == 5'h00 && cfg_q.high_first
        |=> byte_bus_o[5:0] == $past(result_q[0][RES_W-1:8]))
        else $error("high byte not first");
    AST_SIGN_COPY: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        rd_fall && byte_mode && hi_sel |=> byte_bus_o[7:6] == {2{byte_bus_o[5]}})
        else $error("sign copies missing in upper byte");
    AST_BYTE_FLAG: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        !serial_mode && rd_cnt_q < 5'h02 |-> first_channel_flag_o ##1 first_channel_flag_o)
        else $error("flag dropped before channel 1 read");
    AST_SER_FLAG: assert property (@(posedge sclk_i) disable iff (!srst_s2_q)
        !cs_n_i && !pending && ch_q == 3'h0 && bit_q == BIT_LAST |=> !ser_flag)
        else $error("serial flag did not drop after channel 1");

endmodule // aro_readout

// File: test/aro_core_model.sv
/*
 * Converter core stand-in: answers each sample request with eight samples.
 * Assumes single-cycle requests on sys_clk_i and a busy level from the block.
 */
`timescale 1ns/1ns
module aro_core_model
    import aro_pkg::*;
(
    input  wire logic                    sys_clk_i,
    input  wire logic                    busy_i,
    input  wire logic                    sample_req_i,
    input  wire logic [RES_W-1:0]        base_i,
    input  wire logic [7:0]              delay_i,
    output logic [CH_NUM*RES_W-1:0]      sample_data_o,
    output logic                         sample_valid_o
);
    int n;

    // ==========================================================
    // answer: odd samples one code above even ones, so averages round
    initial
    begin
        n = 0;
        sample_valid_o = 1'b0;
        sample_data_o = '0;
        forever
        begin
            @(posedge sys_clk_i);
            #1;
            if (busy_i !== 1'b1)
                n = 0;
            if (sample_req_i === 1'b1)
            begin
                repeat (delay_i) @(posedge sys_clk_i);
                #1;
                for (int c = 0; c < CH_NUM; c++)
                    sample_data_o[c*RES_W +: RES_W] = base_i - RES_W'(c) + RES_W'(n % 2);
                sample_valid_o = 1'b1;
                @(posedge sys_clk_i);
                #1;
                sample_valid_o = 1'b0;
                // stale data must not look valid
                sample_data_o = ~sample_data_o;
                n++;
            end
        end
    end
endmodule // aro_core_model

// File: test/testbench.sv
/*
 * Self-checking bench: byte and serial readout, oversampling ratios.
 * Assumes aro_core_model as converter core; host strobes driven here.
 */
`timescale 1ns/1ns
module testbench
    import aro_pkg::*;
;
    logic                    clk, rst_n, sclk, trig, ifsel, bsel, hbf, cs_n, rd_n;
    logic [2:0]              ratio;
    logic [CH_NUM*RES_W-1:0] sdata;
    logic                    svalid, sreq, busy, bb_oe, sa, sa_oe, sb, sb_oe, fl, fl_oe;
    logic [7:0]              bb, dly;
    logic [0:111]            ra, rb, rf;
    aro_res_t                base;
    int                      errors, total_checks, req_cnt, cur_n, sp;

    aro_readout dut (.sys_clk_i(clk), .rst_n_i(rst_n), .sclk_i(sclk),
        .sample_trigger_i(trig), .ratio_select_i(ratio), .interface_select_i(ifsel),
        .byte_mode_select_i(bsel), .high_byte_first_i(hbf), .cs_n_i(cs_n), .rd_n_i(rd_n),
        .sample_data_i(sdata), .sample_valid_i(svalid), .sample_req_o(sreq),
        .busy_o(busy), .byte_bus_o(bb), .byte_bus_oe_o(bb_oe), .serial_out_a_o(sa),
        .serial_out_a_oe_o(sa_oe), .serial_out_b_o(sb), .serial_out_b_oe_o(sb_oe),
        .first_channel_flag_o(fl), .first_channel_flag_oe_o(fl_oe));

    aro_core_model core (.sys_clk_i(clk), .busy_i(busy), .sample_req_i(sreq),
        .base_i(base), .delay_i(dly), .sample_data_o(sdata), .sample_valid_o(svalid));

    // ==========================================================
    // clock, sample counter, watchdog
    always #4 clk = ~clk;

    always @(posedge clk)
        if (sreq === 1'b1)
            req_cnt++;

    initial
    begin
        #400_000;
        errors++;
        $display("BAD watchdog expected done seen timeout");
        stop_test();
    end

    // ==========================================================
    // helpers
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [13:0] res(input int c, input int ns);
        int sum;
        sum = 0;
        for (int k = 0; k < ns; k++)
            sum += int'(base) - c + k % 2;
        return 14'((sum + ns / 2) >>> $clog2(ns));
    endfunction

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic convert(input logic [2:0] code);
        int w;
        @(posedge clk);
        #1;
        ratio = code;
        req_cnt = 0;
        w = 0;
        trig = 1'b1; // one pin serves both triggers
        while (busy !== 1'b1 && w < 20)
        begin
            @(posedge clk);
            #1;
            w++;
        end
        trig = 1'b0;
        while (busy !== 1'b0 && w < 9000)
        begin
            @(posedge clk);
            #1;
            w++;
        end
        chk("busy", 16'h0, 16'(busy));
        chk("samples", 16'(cur_n), 16'(req_cnt));
        cur_n = (code == 3'h0 || code == 3'h7) ? 1 : 1 << code;
        repeat (4) @(posedge clk);
    endtask

    task automatic rd_byte(output logic [7:0] b, output logic f);
        @(posedge clk);
        #1;
        rd_n = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        b = bb;
        f = fl;
        chk("byte oe", 16'h1, 16'(bb_oe));
        rd_n = 1'b1;
        repeat (4) @(posedge clk);
    endtask

    task automatic read_ch(input int c, input int ns);
        logic [13:0] r;
        logic [7:0]  b0, b1;
        logic        f0, f1;
        r = res(c, ns);
        rd_byte(b0, f0);
        rd_byte(b1, f1);
        chk("first byte", hbf ? {r[13], r[13], r[13:8]} : r[7:0], 16'(b0));
        chk("second byte", hbf ? r[7:0] : {r[13], r[13], r[13:8]}, 16'(b1));
        chk("byte flag", 16'({2{c == 0}}), 16'({f0, f1}));
    endtask

    // idle host clock pulses let the new-data toggle cross
    task automatic sclk_pulses(input int n);
        repeat (n)
        begin
            #80 sclk = 1'b0;
            #80 sclk = 1'b1;
        end
    endtask

    task automatic sframe(input int nb);
        #3 cs_n = 1'b0;
        for (int i = 0; i < nb; i++)
        begin
            #80 sclk = 1'b0;
            #40 ra[sp] = sa;
            rb[sp] = sb;
            rf[sp] = fl;
            if (sp == 0)
                chk("serial oe", 16'h7, 16'({sa_oe, sb_oe, fl_oe}));
            sp++;
            #40 sclk = 1'b1;
        end
        #80 cs_n = 1'b1;
        #20 chk("flag released", 16'h0, 16'(fl_oe));
    endtask

    // ==========================================================
    // tests
    initial
    begin
        {clk, rst_n, trig, cs_n, rd_n, sclk} = 6'b000011;
        {ifsel, bsel, hbf, ratio, dly, base} = '0;
        {errors, total_checks, req_cnt, sp, cur_n} = {32'd0, 32'd0, 32'd0, 32'd0, 32'd1};
        dly = 8'h02;
        ifsel = 1'b1;
        bsel = 1'b1; // byte-wide mode
        hbf = 1'b1;
        cs_n = 1'b0;
        // held past two rising host clock edges so that domain is reset too
        sclk_pulses(2);
        @(posedge clk);
        #1 rst_n = 1'b1;
        convert(3'h0);
        base = -14'sd300;
        convert(3'h0);
        for (int c = 0; c < CH_NUM; c++)
            read_ch(c, 1);
        $display("test byte high first done");
        hbf = 1'b0;
        base = 14'sd1234;
        convert(3'h0);
        for (int c = 0; c < CH_NUM; c++)
            read_ch(c, 1);
        $display("test byte low first done");
        hbf = 1'b1;
        for (int k = 1; k < 8; k++)
        begin
            base = 14'(k * 700 - 2900);
            convert(3'(k));
            convert(3'(k));
            read_ch(0, cur_n);
        end
        $display("test oversampling done");
        dly = 8'h3c;
        fork
            convert(3'h0);
            begin
                repeat (8) @(posedge clk);
                read_ch(1, 1); // previous results while busy
                base = 14'sd77;
            end
        join
        dly = 8'h02;
        read_ch(0, 1);
        $display("test read during busy done");
        cs_n = 1'b1;
        bsel = 1'b0; // serial mode
        convert(3'h0);
        base = -14'sd5;
        convert(3'h0);
        sclk_pulses(2);
        sframe(56);
        for (int k = 0; k < 4; k++)
            sframe(14);
        for (int k = 0; k < 4; k++)
        begin
            chk("lane a", 16'(res(k, 1)), 16'(ra[k*14 +: 14]));
            chk("lane b", 16'(res(k + 4, 1)), 16'(rb[k*14 +: 14]));
            chk("lane b wrap", 16'(res(k, 1)), 16'(rb[56 + k*14 +: 14]));
        end
        chk("flag high", 16'h3fff, 16'(rf[0 +: 14]));
        chk("flag low", 16'h0, 16'(|rf[14:111]));
        $display("test serial done");
        stop_test();
    end
endmodule // testbench
